// ===== adcsr_defs.svh
`ifndef ADCSR_DEFS_SVH
`define ADCSR_DEFS_SVH

// Frame layout
`define ADCSR_FRAME_BITS    19
`define ADCSR_RESULT_BITS   16
`define ADCSR_BIT_PENDING   18
`define ADCSR_BIT_CHANNEL   17
`define ADCSR_BIT_SIGN      16
`define ADCSR_LAST_FALL     5'h12

// Raw filter word and its clamping
`define ADCSR_RAW_BITS      18
`define ADCSR_RAW_MAX       18'sh08000
`define ADCSR_RAW_MIN       18'sh37fff
`define ADCSR_RAW_OFFSET    18'h10000
`define ADCSR_CODE_OVER     17'h18000
`define ADCSR_CODE_UNDER    17'h07fff

// Timing
`define ADCSR_CLK_HZ        40000000
`define ADCSR_EXT_MIN_HZ    2560
`define ADCSR_EXT_TIMEOUT   ((`ADCSR_CLK_HZ + `ADCSR_EXT_MIN_HZ - 1) / `ADCSR_EXT_MIN_HZ)
`define ADCSR_CONV_TICKS    20510
`define ADCSR_INT_DIV       287
`define ADCSR_SCK_DIV       8
`define ADCSR_FIFO_DEPTH    16

`endif

// ===== adcsr_fifo.sv
`timescale 1ns/10ps

// Result buffer; output word always comes from a register
module adcsr_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    adcsr_stream_if.snk     s_in,
    adcsr_stream_if.src     s_out
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad_fifo
        $error("adcsr_fifo: depth must be a power of two >= 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;   // Storage
        logic [AW-1:0]               wr;    // Write pointer
        logic [AW-1:0]               rd;    // Read pointer
        logic [AW:0]                 cnt;   // Words in storage
        logic                        oval;  // Output register full
        logic [WIDTH-1:0]            odat;  // Output register
    } adcsr_fifo_type;

    adcsr_fifo_type core;
    adcsr_fifo_type next_core;
    logic           push;
    logic           load;

    // Back-pressure: refuse while storage is full
    assign s_in.ready  = (core.cnt != (AW+1)'(DEPTH));
    assign s_out.valid = core.oval;
    assign s_out.data  = core.odat;

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        next_core = core;
        push = s_in.valid && s_in.ready;
        // Refill output register when empty or being taken
        load = (!core.oval || s_out.ready) && (core.cnt != '0);
        if (s_out.ready && core.oval)
        begin
            next_core.oval = 1'b0;
        end
        if (load)
        begin
            next_core.odat = core.mem[core.rd];
            next_core.oval = 1'b1;
            next_core.rd   = core.rd + 1'b1;
        end
        if (push)
        begin
            next_core.mem[core.wr] = s_in.data;
            next_core.wr           = core.wr + 1'b1;
        end
        next_core.cnt = core.cnt + (AW+1)'(push) - (AW+1)'(load);
    end

    // State register
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            core <= '0;
        end
        else
        begin
            core <= next_core;
        end
    end
endmodule

// ===== adcsr_host.sv
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Host controller model: drives select and serial clock, reads frames
module adcsr_host #(
    parameter int HALF = 4               // Clock half period, in i_clk cycles
) (
    input  wire logic        i_clk,
    input  wire logic        i_sdo,      // Data wire as the host sees it
    input  wire logic        i_sck,      // Clock wire as the host sees it
    output logic             o_cs_n,     // Select, active low
    output logic             o_sck,      // Host clock drive
    output logic             o_sck_oe_n, // Low while the host drives the clock
    output logic [23:0]      o_frame,    // Captured bits, newest in bit 0
    output logic [4:0]       o_nbits,    // Count of captured bits
    output logic             o_done,     // One-cycle mark after each transfer
    output logic [15:0]      o_period    // Cycles between device clock rises
);
    int cyc = 0;                         // Running cycle count

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counter, only for clock period capture
    always @(posedge i_clk)
        cyc <= cyc + 1;

    // Idle: deselected, clock held low so external mode gets picked
    initial
    begin
        o_cs_n     = 1'b1;
        o_sck      = 1'b0;
        o_sck_oe_n = 1'b0;
        o_frame    = '0;
        o_nbits    = '0;
        o_done     = 1'b0;
        o_period   = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample on rise
    task automatic pulse(input bit cap);
        repeat (HALF) @(negedge i_clk);
        if (cap)
            o_frame = {o_frame[22:0], i_sdo};
        o_sck = 1'b1;
        repeat (HALF) @(negedge i_clk);
        o_sck = 1'b0;
    endtask

    // Quiet while deselected: callers use this only in sleep
    task automatic pulses(input int n);
        repeat (n) pulse(1'b0);
    endtask

    // Select without clocking, to watch the pending flag
    task automatic select();
        @(negedge i_clk);
        o_cs_n = 1'b0;
    endtask

    // One transfer of n bits; ext picks who makes the clock
    task automatic xfer(input int n, input bit ext, input bit keep);
        int last;
        int k;
        last = 0;
        k = 0;
        @(negedge i_clk);
        // A released pin floats high, which asks for internal mode
        o_sck_oe_n = !ext;
        @(negedge i_clk);
        o_cs_n = 1'b0;
        repeat (2) @(negedge i_clk);
        // Wait for the pending flag to drop
        while (i_sdo !== 1'b0 && k < 5000)
        begin
            @(negedge i_clk);
            k++;
        end
        o_frame = '0;
        for (int i = 0; i < n; i++)
            if (ext)
                pulse(1'b1);
            else
            begin
                @(posedge i_sck);
                o_frame = {o_frame[22:0], i_sdo};
                o_period = 16'(cyc - last);
                last = cyc;
            end
        // Extra pulses end long before the next conversion can
        repeat (40) @(negedge i_clk);
        if (!keep)
            o_cs_n = 1'b1;
        o_nbits = 5'(n);
        o_done = 1'b1;
        @(negedge i_clk);
        o_done = 1'b0;
        // Take the clock back only once the device has let go
        if (!keep)
        begin
            repeat (2) @(negedge i_clk);
            o_sck_oe_n = 1'b0;
        end
    endtask
endmodule

// ===== adcsr_pkg.sv
package adcsr_pkg;

    // Converter operating cycle
    typedef enum logic [1:0] {
        ST_CONVERT,
        ST_SLEEP,
        ST_OUTPUT
    } adcsr_state_type;

endpackage

// ===== adcsr_port.sv
`timescale 1ns/10ps
`include "adcsr_defs.svh"
module adcsr_port
    import adcsr_pkg::*;
#(
    parameter int FIFO_DEPTH  = `ADCSR_FIFO_DEPTH,
    parameter int CONV_TICKS  = `ADCSR_CONV_TICKS,
    parameter int INT_DIV     = `ADCSR_INT_DIV,
    parameter int EXT_TIMEOUT = `ADCSR_EXT_TIMEOUT
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_resetn,
    input  wire logic                       i_cs_n,
    input  wire logic                       i_sck,
    output logic                            o_sck,
    output logic                            o_sck_oe_n,
    output logic                            o_sdo,
    output logic                            o_sdo_oe_n,
    input  wire logic                       i_conversion_clock_pin,
    input  wire logic                       i_sample_valid,
    input  wire logic [`ADCSR_RAW_BITS-1:0] i_sample_data,
    output logic                            o_sample_ready,
    output logic                            o_ext_clock
);
    localparam int CW = $clog2(CONV_TICKS + 1);
    localparam int OW = $clog2(INT_DIV + 1);
    localparam int IW = $clog2(EXT_TIMEOUT + 1);

    if (CONV_TICKS < 1 || INT_DIV < 2 || EXT_TIMEOUT < 2 || FIFO_DEPTH < 2)
    begin : g_bad_param
        $error("adcsr_port: counts out of range");
    end

    typedef struct packed {
        adcsr_state_type         st;          // Operating state
        logic [`ADCSR_FRAME_BITS-1:0] shift;  // Output shifter
        logic [4:0]              fall_cnt;    // Falling edges in frame
        logic                    int_sck;     // Internal serial clock mode
        logic                    sel_pending; // Mode pick after reset
        logic                    ch;          // Channel now converting
        logic                    cs_q;        // Select, last cycle
        logic                    sck_q;       // Serial clock, last cycle
        logic                    fpin_q;      // Conversion clock pin, last
        logic [CW-1:0]           conv_cnt;    // Conversion ticks so far
        logic [OW-1:0]           osc_cnt;     // Internal oscillator divider
        logic [IW-1:0]           idle_cnt;    // Cycles since pin edge
        logic                    ext_on;      // External clock present
        logic [2:0]              div_cnt;     // Serial clock divider
        logic                    isck;        // Generated serial clock
        logic                    sck_drv;     // Driving clock pin
        logic                    sdo;         // Data pin level
        logic                    sdo_en;      // Data pin driven
    } adcsr_core_type;

    adcsr_core_type core;
    adcsr_core_type next_core;

    adcsr_stream_if #(.WIDTH(`ADCSR_RAW_BITS)) buf_in ();
    adcsr_stream_if #(.WIDTH(`ADCSR_RAW_BITS)) buf_out ();

    logic        tick;      // One conversion clock period
    logic        fpin_rise; // External clock edge
    logic        run;       // Internal clock generation active
    logic        rise;      // Serial clock rising, either source
    logic        fall;      // Serial clock falling, either source
    logic        start;     // Begin a conversion
    logic        pop;       // Take a result from the buffer
    logic [16:0] code;      // Sign plus result after clamping
    logic [`ADCSR_RAW_BITS-1:0] biased;

    ////////////////////////////////////////////////////////////////////
    // Result buffer; stalls the filter while its storage is full
    assign buf_in.valid   = i_sample_valid;
    assign buf_in.data    = i_sample_data;
    assign o_sample_ready = buf_in.ready;
    assign buf_out.ready  = pop;

    adcsr_fifo #(
        .WIDTH (`ADCSR_RAW_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .s_in     (buf_in),
        .s_out    (buf_out)
    );

    assign o_sck       = core.isck;
    assign o_sck_oe_n  = ~core.sck_drv;
    assign o_sdo       = core.sdo;
    assign o_sdo_oe_n  = ~core.sdo_en;
    assign o_ext_clock = core.ext_on;

    ////////////////////////////////////////////////////////////////////
    // Result coding
    always_comb
    begin
        biased = buf_out.data + `ADCSR_RAW_OFFSET;
        if ($signed(buf_out.data) > `ADCSR_RAW_MAX)
        begin
            code = `ADCSR_CODE_OVER;
        end
        else if ($signed(buf_out.data) < `ADCSR_RAW_MIN)
        begin
            code = `ADCSR_CODE_UNDER;
        end
        else
        begin
            code = biased[16:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        next_core        = core;
        next_core.cs_q   = i_cs_n;
        next_core.sck_q  = i_sck;
        next_core.fpin_q = i_conversion_clock_pin;
        start = 1'b0;
        pop   = 1'b0;

        fpin_rise = i_conversion_clock_pin && !core.fpin_q;
        if (fpin_rise)
        begin
            next_core.idle_cnt = '0;
            next_core.ext_on   = 1'b1;
        end
        else if (core.idle_cnt == IW'(EXT_TIMEOUT - 1))
        begin
            // quiet pin falls back to oscillator
            next_core.ext_on = 1'b0;
        end
        else
        begin
            next_core.idle_cnt = core.idle_cnt + 1'b1;
        end

        // Oscillator held still while external clock runs
        if (core.ext_on || core.osc_cnt == OW'(INT_DIV - 1))
        begin
            next_core.osc_cnt = '0;
        end
        else
        begin
            next_core.osc_cnt = core.osc_cnt + 1'b1;
        end
        // source swap only shifts tick timing
        tick = core.ext_on ? fpin_rise : (core.osc_cnt == OW'(INT_DIV - 1));

        if (core.sel_pending)
        begin
            next_core.int_sck     = i_sck;
            next_core.sel_pending = 1'b0;
        end
        else if (core.cs_q && !i_cs_n)
        begin
            next_core.int_sck = i_sck;
        end

        run = core.int_sck && !core.cs_q && !i_cs_n && core.st != ST_CONVERT;
        if (!run)
        begin
            next_core.div_cnt = '0;
            next_core.isck    = 1'b0;
        end
        else if (tick)
        begin
            next_core.div_cnt = core.div_cnt + 1'b1;
            if (core.div_cnt[1:0] == 2'b11)
            begin
                next_core.isck = ~core.isck;
            end
        end
        // pin left alone in external mode
        next_core.sck_drv = run;

        // clock edges count only while selected
        if (core.int_sck)
        begin
            rise = run && tick && core.div_cnt[1:0] == 2'b11 && !core.isck;
            fall = run && tick && core.div_cnt[1:0] == 2'b11 && core.isck;
        end
        else
        begin
            rise = !i_cs_n && i_sck && !core.sck_q;
            fall = !i_cs_n && !i_sck && core.sck_q;
        end

        case (core.st)
            ST_CONVERT:
            begin
                if (core.conv_cnt != CW'(CONV_TICKS))
                begin
                    if (tick)
                    begin
                        next_core.conv_cnt = core.conv_cnt + 1'b1;
                    end
                end
                else if (buf_out.valid)
                begin
                    pop = 1'b1;
                    next_core.shift = {1'b0, core.ch, code};
                    next_core.st    = ST_SLEEP;
                end
            end
            ST_SLEEP:
            begin
                if (!i_cs_n && rise)
                begin
                    next_core.st       = ST_OUTPUT;
                    next_core.fall_cnt = '0;
                end
            end
            ST_OUTPUT:
            begin
                if (i_cs_n)
                begin
                    start = 1'b1;
                end
                else if (fall)
                begin
                    next_core.shift    = {core.shift[17:0], 1'b1};
                    next_core.fall_cnt = core.fall_cnt + 1'b1;
                    if (core.fall_cnt == `ADCSR_LAST_FALL)
                    begin
                        start = 1'b1;
                    end
                end
            end
            default:
            begin
                start = 1'b1;
            end
        endcase

        if (start)
        begin
            next_core.st       = ST_CONVERT;
            next_core.conv_cnt = '0;
            next_core.ch       = ~core.ch;
            next_core.fall_cnt = '0;
        end

        // flag follows state without a clock
        next_core.sdo    = (next_core.st == ST_CONVERT) || next_core.shift[18];
        next_core.sdo_en = !i_cs_n;
    end

    // State register
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            core             <= '0;
            core.cs_q        <= 1'b1;
            core.sel_pending <= 1'b1;
            core.sdo         <= 1'b1;
        end
        else
        begin
            core <= next_core;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    a_sdo_float: assert property (i_cs_n |=> o_sdo_oe_n)
        else $error("data pin driven while deselected");
    a_pending_flag: assert property (core.st == ST_CONVERT |-> o_sdo)
        else $error("pending flag low during conversion");
    a_frame_load: assert property (pop |=> core.st == ST_SLEEP && !core.shift[18])
        else $error("frame not loaded at completion");
    a_channel_bit: assert property (pop |=> core.shift[17] == $past(core.ch))
        else $error("channel bit wrong");
    a_clamp_over: assert property (pop && $signed(buf_out.data) > `ADCSR_RAW_MAX
        |=> core.shift[16:0] == `ADCSR_CODE_OVER)
        else $error("overrange code wrong");
    a_clamp_under: assert property (pop && $signed(buf_out.data) < `ADCSR_RAW_MIN
        |=> core.shift[16:0] == `ADCSR_CODE_UNDER)
        else $error("underrange code wrong");
    a_frame_end: assert property (core.st == ST_OUTPUT && !i_cs_n && fall
        && core.fall_cnt == `ADCSR_LAST_FALL |=> core.st == ST_CONVERT && o_sdo)
        else $error("no conversion after last bit");
    a_abort_out: assert property (core.st == ST_OUTPUT && i_cs_n
        |=> core.st == ST_CONVERT)
        else $error("deselect did not abort");
    a_sleep_keep: assert property (core.st == ST_SLEEP && i_cs_n
        |=> core.st == ST_SLEEP && $stable(core.shift))
        else $error("result lost in sleep");
    a_ext_no_drive: assert property (!core.int_sck |-> o_sck_oe_n)
        else $error("clock pin driven in external mode");

    c_full_frame: cover property (core.st == ST_OUTPUT ##1 core.st == ST_CONVERT
        && core.fall_cnt == '0 && !i_cs_n);
    c_abort: cover property (core.st == ST_OUTPUT && i_cs_n);
    c_int_clock: cover property (core.sck_drv && rise);
    c_ext_clock: cover property ($rose(core.ext_on));
endmodule

// ===== adcsr_stream_if.sv
`timescale 1ns/10ps

// Valid/ready word stream between the port and its buffer
interface adcsr_stream_if #(parameter int WIDTH = 18);
    logic             valid;  // Word offered
    logic             ready;  // Word accepted
    logic [WIDTH-1:0] data;   // Word itself

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ===== testbench.sv
`timescale 1ns/10ps

`define CHK(g, e) \
    begin \
        tests_run++; \
        if ((g) !== (e)) \
        begin \
            fail_count++; \
            $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e); \
        end \
    end

////////////////////////////////////////////////////////////////////////////////
// Top bench: sample source, host model, frame comparer
module testbench;
    localparam int DIV = 3;              // Shortened internal tick divider
    localparam int ETO = 40;             // Shortened clock-loss timeout

    logic        clk = 1'b0;
    logic        resetn;
    logic        cs_n, h_sck, h_oe_n, done;
    logic        dut_sck, sck_oe_n, sdo, sdo_oe_n, ext_clk;
    logic        pin, valid, ready, sck_w, sdo_w;
    logic        sdo_last = 1'b1;        // Last driven data level
    logic        exp_ch = 1'b0;          // Channel of the next frame
    logic [1:0]  cs_d = 2'b00;           // Select history
    logic [1:0]  hd = 2'b11;             // Host clock enable history
    logic [17:0] data;
    logic [23:0] frame, exp24;
    logic [4:0]  nbits;
    logic [15:0] period;
    logic [16:0] notes[$];               // Expected codes, oldest first
    int          fail_count = 0;
    int          tests_run = 0;
    int          seed = 32'hc8000e5b;
    logic [17:0] bound[10] = '{18'h00000, 18'h3ffff, 18'h07fff, 18'h08000,
        18'h08001, 18'h38000, 18'h37fff, 18'h37ffe, 18'h1ffff, 18'h20000};

    always #12.5 clk = ~clk;

    // Pin levels: pull-up on the clock; released data shows stale inverse
    assign sck_w = !sck_oe_n ? dut_sck : (!h_oe_n ? h_sck : 1'b1);
    assign sdo_w = sdo_oe_n ? ~sdo_last : sdo;
    always @(posedge clk)
        if (!sdo_oe_n)
            sdo_last <= sdo;

    adcsr_port #(.CONV_TICKS(20), .INT_DIV(DIV), .EXT_TIMEOUT(ETO)) dut_u (
        .i_clk(clk), .i_resetn(resetn), .i_cs_n(cs_n), .i_sck(sck_w),
        .o_sck(dut_sck), .o_sck_oe_n(sck_oe_n), .o_sdo(sdo),
        .o_sdo_oe_n(sdo_oe_n), .i_conversion_clock_pin(pin),
        .i_sample_valid(valid), .i_sample_data(data),
        .o_sample_ready(ready), .o_ext_clock(ext_clk));

    adcsr_host host_u (
        .i_clk(clk), .i_sdo(sdo_w), .i_sck(sck_w), .o_cs_n(cs_n),
        .o_sck(h_sck), .o_sck_oe_n(h_oe_n), .o_frame(frame),
        .o_nbits(nbits), .o_done(done), .o_period(period));

    ////////////////////////////////////////////////////////////////////////////
    // Code that a raw sample must give, clamped one step past full scale
    function automatic logic [16:0] code_of(input logic signed [17:0] r);
        if (r > 18'sh08000)
            return 17'h18000;
        if (r < 18'sh37fff)
            return 17'h07fff;
        return 17'(r + 18'sh10000);
    endfunction

    // Offer one word, held until taken, and note what it must become
    task automatic put(input logic [17:0] d);
        int k;
        k = 0;
        @(negedge clk);
        valid = 1'b1;
        data = d;
        @(posedge clk);
        while (!ready && k < 5000)
        begin
            @(posedge clk);
            k++;
        end
        notes.push_back(code_of(d));
        @(negedge clk);
        valid = 1'b0;
    endtask

    task automatic stage(input string s);
        $display("test finished: %s", s);
    endtask

    task automatic test_done();
        $display("checks %0d, failures %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Comparer: each finished transfer of one or more bits takes the oldest note
    always @(posedge clk)
    begin
        if (done && nbits != 0)
        begin
            if (notes.size() == 0)
            begin
                fail_count++;
                $display("CHECK FAILED at %0t: frame without a note", $time);
            end
            else
            begin
                exp24 = {1'b0, exp_ch, notes.pop_front(), 5'h1f};
                `CHK(frame, exp24 >> (24 - nbits))
                exp_ch = !exp_ch;
            end
        end
        cs_d <= {cs_d[0], cs_n};
        hd <= {hd[0], h_oe_n};
        if (cs_d == 2'b11)
            `CHK(sdo_oe_n, 1'b1)
        if (hd == 2'b00)
            `CHK(sck_oe_n, 1'b1)
    end

    // Watchdog against a hung handshake
    initial
    begin
        repeat (40000) @(posedge clk);
        fail_count++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        resetn = 1'b0;
        valid = 1'b0;
        data = '0;
        pin = 1'b0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        put(18'h00000);
        host_u.select();
        repeat (3) @(negedge clk);
        `CHK(sdo_w, 1'b1)
        host_u.xfer(19, 1'b1, 1'b1);
        `CHK(sdo_w, 1'b1)
        put(18'($random(seed)));
        for (int k = 0; k < 5000 && sdo_w !== 1'b0; k++)
            @(negedge clk);
        `CHK(sdo_w, 1'b0)
        stage("status flag");
        // Fill while the host stalls: sixteen stored plus one staged
        foreach (bound[i])
            put(bound[i]);
        repeat (7) put(18'($random(seed)));
        `CHK(ready, 1'b0)
        stage("buffer fill");
        host_u.xfer(24, 1'b1, 1'b0);
        repeat (100) @(negedge clk);
        host_u.pulses(5);
        host_u.xfer(19, 1'b1, 1'b0);
        host_u.xfer(0, 1'b1, 1'b0);
        host_u.xfer(19, 1'b1, 1'b0);
        host_u.xfer(5, 1'b1, 1'b0);
        host_u.xfer(19, 1'b1, 1'b0);
        stage("extra, ignored, kept and aborted");
        host_u.xfer(19, 1'b0, 1'b0);
        `CHK(period, 16'(8 * DIV))
        stage("internal clock");
        fork
            repeat (200)
            begin
                repeat (3) @(negedge clk);
                pin = ~pin;
            end
        join_none
        host_u.xfer(19, 1'b1, 1'b0);
        `CHK(ext_clk, 1'b1)
        wait fork;
        repeat (ETO + 10) @(negedge clk);
        `CHK(ext_clk, 1'b0)
        stage("conversion clock");
        // Drain in random clock modes
        while (notes.size() > 0)
            host_u.xfer(19, 1'($random(seed)), 1'b0);
        stage("drain");
        test_done();
    end
endmodule
